/* File: hdl/phy_status_control_pins.sv */
// dual port status LEDs, mac clock, power down and interrupt pins
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "phy_pins_defs.svh"

module phy_status_control_pins
    import phy_pins_pkg::*;
#(
    parameter int NPORT          = 2,
    parameter int BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire port_status_t        port_status [NPORT],
    input  wire logic                mac_clk_dis_strap,
    input  wire logic                led_mode_strap,
    output logic                     mac_clock_out,
    input  wire led_t                led_in  [NPORT],
    output led_t                     led_out [NPORT],
    output led_t                     led_oe  [NPORT],
    input  wire logic                powerdown_irq_pin_in  [NPORT],
    output logic                     powerdown_irq_pin_out [NPORT],
    output logic                     powerdown_irq_pin_oe  [NPORT],
    output logic                     powerdown [NPORT],
    output logic                     irq
);

    localparam int MII_DIV  = `CLK_HZ / `MII_CLK_HZ;
    localparam int RMII_DIV = `CLK_HZ / `RMII_CLK_HZ;
    localparam int BW       = $clog2(BLINK_HALF_CYC + 1);
    // link and collision event bits of port 0; port p shifts by p
    localparam logic [`IRQ_W-1:0] PORT_EV = 4'h5;

    logic [`CTRL_W-1:0] ctrl_ff;
    logic [`IRQ_W-1:0]  irq_stat_ff;
    logic [`IRQ_W-1:0]  irq_mask_ff;
    logic [`IRQ_W-1:0]  nxt_irq_stat;
    logic [31:0]        prdata_ff;
    logic [31:0]        nxt_prdata;
    logic               strap_done_ff;
    logic               mac_dis_ff;
    logic               mode_strap_ff;
    led_t               pol_ff [NPORT];
    logic [3:0]         div_cnt_ff;
    logic               mac_clk_ff;
    logic [BW-1:0]      blink_cnt_ff;
    logic               blink_ff;
    logic [NPORT-1:0]   link_d_ff;
    logic [NPORT-1:0]   col_d_ff;
    logic [`IRQ_W-1:0]  ev;
    logic               acc;
    logic               wr;
    logic               rd;
    logic               hit;

    // ------------------------------------------------------------ apb
    assign acc = psel & penable;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;

    // no wait states: every access finishes in its first access cycle
    assign pready = 1'b1;

    always_comb begin
        hit = 1'b1;
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            `REG_CTRL: begin
                nxt_prdata[`CTRL_W-1:0] = ctrl_ff;
            end
            `REG_STATUS: begin
                nxt_prdata[0] = strap_done_ff;
                nxt_prdata[1] = mac_dis_ff;
                nxt_prdata[2] = mode_strap_ff;
                nxt_prdata[4:3] = {powerdown[1], powerdown[0]};
                nxt_prdata[6:5] = link_d_ff;
            end
            `REG_IRQ_STAT: begin
                nxt_prdata[`IRQ_W-1:0] = irq_stat_ff;
            end
            `REG_IRQ_MASK: begin
                nxt_prdata[`IRQ_W-1:0] = irq_mask_ff;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    assign pslverr = acc & ~hit;
    assign prdata  = prdata_ff;

    // read data registered at the setup phase so it is stable in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin // [RL13]
        if (!presetn) begin
            ctrl_ff <= `CTRL_RST;
        end else if (wr && paddr == `REG_CTRL) begin
            ctrl_ff <= pwdata[`CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_ff <= `IRQ_MASK_RST;
        end else if (wr && paddr == `REG_IRQ_MASK) begin
            irq_mask_ff <= pwdata[`IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------ straps
    // caught on the first edge after release; asynchronous reset
    // itself only loads constants, so the pins are sampled here
    always_ff @(posedge pclk or negedge presetn) begin // [RL12] [RL13]
        if (!presetn) begin
            strap_done_ff <= 1'b0;
            mac_dis_ff    <= 1'b0;
            mode_strap_ff <= 1'b0;
        end else if (!strap_done_ff) begin
            strap_done_ff <= 1'b1;
            mac_dis_ff    <= mac_clk_dis_strap;
            mode_strap_ff <= led_mode_strap; // [RL4]
        end
    end

    // ---------------------------------------------------- mac clock
    // the RMII divider is odd, so its high phase is one cycle shorter
    always_ff @(posedge pclk or negedge presetn) begin // [RL1]
        if (!presetn) begin
            div_cnt_ff <= 4'h0;
            mac_clk_ff <= 1'b0;
        end else begin
            if (ctrl_ff[`CTRL_RMII]) begin
                if (32'(div_cnt_ff) >= RMII_DIV - 1) begin
                    div_cnt_ff <= 4'h0;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 4'h1;
                end
                mac_clk_ff <= 32'(div_cnt_ff) < RMII_DIV / 2;
            end else begin
                if (32'(div_cnt_ff) >= MII_DIV - 1) begin
                    div_cnt_ff <= 4'h0;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 4'h1;
                end
                mac_clk_ff <= 32'(div_cnt_ff) < MII_DIV / 2;
            end
        end
    end

    assign mac_clock_out = mac_clk_ff & strap_done_ff
                         & ~mac_dis_ff; // [RL2]

    // -------------------------------------------------------- blink
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_cnt_ff <= '0;
            blink_ff     <= 1'b0;
        end else if (32'(blink_cnt_ff) >= BLINK_HALF_CYC - 1) begin
            blink_cnt_ff <= '0;
            blink_ff     <= ~blink_ff;
        end else begin
            blink_cnt_ff <= blink_cnt_ff + BW'(1);
        end
    end

    // ------------------------------------------------------ events
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_d_ff <= '0;
            col_d_ff  <= '0;
        end else begin
            for (int i = 0; i < NPORT; i++) begin
                link_d_ff[i] <= port_status[i].link_good;
                col_d_ff[i]  <= port_status[i].collision;
            end
        end
    end

    always_comb begin
        nxt_irq_stat = irq_stat_ff;
        if (rd && paddr == `REG_IRQ_STAT) begin
            nxt_irq_stat = '0;
        end
        // a new event in the clearing cycle survives the clear
        nxt_irq_stat = nxt_irq_stat | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= '0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // ------------------------------------------------------- ports
    genvar p;
    generate
        for (p = 0; p < NPORT; p++) begin : g_port
            led_mode_t mode;
            led_t      lit;
            logic      active;
            logic      pending;

            assign ev[`IRQ_LINK + p] =
                port_status[p].link_good ^ link_d_ff[p];
            assign ev[`IRQ_COL + p] =
                port_status[p].collision & ~col_d_ff[p];

            // software mode three overrides the strap choice
            always_comb begin // [RL4] [RL5]
                if (ctrl_ff[`CTRL_MODE3 + p]) begin
                    mode = LED_MODE3;
                end else if (mode_strap_ff) begin
                    mode = LED_MODE2;
                end else begin
                    mode = LED_MODE1;
                end
            end

            assign active = port_status[p].tx_active
                          | port_status[p].rx_active;

            always_comb begin // [RL17]
                lit.speed = port_status[p].speed100; // [RL8]
                unique case (mode)
                    LED_MODE1: begin
                        lit.link   = port_status[p].link_good; // [RL6]
                        lit.actcol = active; // [RL9]
                    end
                    LED_MODE2: begin
                        lit.link   = port_status[p].link_good
                                   & ~(active & blink_ff); // [RL7]
                        lit.actcol = port_status[p].collision; // [RL10]
                    end
                    default: begin
                        lit.link   = port_status[p].link_good
                                   & ~(active & blink_ff); // [RL7]
                        lit.actcol = ctrl_ff[`CTRL_DUPSEL + p]
                                   ? port_status[p].full_duplex
                                   : port_status[p].collision; // [RL11]
                    end
                endcase
            end

            // pull level latched once straps are taken
            always_ff @(posedge pclk or negedge presetn) begin // [RL3]
                if (!presetn) begin
                    pol_ff[p] <= '0;
                end else if (!strap_done_ff) begin
                    pol_ff[p] <= led_in[p]; // [RL18]
                end
            end

            // pulled up means active low; pins float until straps done
            assign led_out[p] = lit ^ pol_ff[p]; // [RL3]
            assign led_oe[p]  = strap_done_ff ? 3'b111 : 3'b000; // [RL18]

            assign pending = |(irq_stat_ff & irq_mask_ff
                             & (PORT_EV << p));

            // open drain: only ever drives low, and only in irq function
            assign powerdown_irq_pin_out[p] = 1'b0; // [RL15]
            assign powerdown_irq_pin_oe[p]  =
                ctrl_ff[`CTRL_INTFN + p] & pending; // [RL15] [RL16]
            assign powerdown[p] = ~ctrl_ff[`CTRL_INTFN + p]
                                & ~powerdown_irq_pin_in[p]; // [RL14]
        end
    endgenerate

endmodule // phy_status_control_pins

/* File: hdl/phy_pins_defs.svh */
// constants for the transceiver status and control pin block
// Operation
// RL1: mac clock output runs at 25 MHz for MII, 50 MHz for RMII.
// RL2: latched mac clock disable strap holds the mac clock output off.
// RL3: each LED lit level is the opposite of its strap pull level.
// RL4: latched LED mode strap picks mode one or two; mode three exists.
// RL5: software bit selects mode three, overriding the strap choice.
// RL6: mode one link indicator lit exactly while link is good.
// RL7: modes two and three link lit when good, blinking while active.
// RL8: speed indicator lit at 100 Mb/s, unlit at 10 Mb/s, every mode.
// RL9: mode one activity indicator lit while transmit or receive active.
// RL10: mode two activity/collision indicator shows collisions.
// RL11: mode three indicator may show full duplex instead of collision.
// RL12: reset input held low at least 1 us forces a full reset.
// RL13: hardware reset restores all registers and relatches every strap.
// RL14: after reset the pin is an active low power down input.
// RL15: in interrupt function the pin pulls low while interrupt pending.
// RL16: software switches the pin to interrupt function before use.
// RL17: each port has its own LEDs and pin, driven by its own status.
// RL18: LED straps sampled in reset; indicator function only after release. The code samples them on the first edge after release.
`ifndef PHY_PINS_DEFS_SVH
`define PHY_PINS_DEFS_SVH

`define CLK_HZ          250000000
`define CLK_MHZ         250
`define MII_CLK_HZ      25000000
`define RMII_CLK_HZ     50000000
`define RST_MIN_NS      1000
`define RST_MIN_CYC     ((`RST_MIN_NS * `CLK_MHZ + 999) / 1000)
`define BLINK_HALF_US   50000
`define BLINK_HALF_CYC  (`BLINK_HALF_US * `CLK_MHZ)

`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_IRQ_STAT    12'h008
`define REG_IRQ_MASK    12'h00C

`define CTRL_RMII       0
`define CTRL_MODE3      1
`define CTRL_DUPSEL     3
`define CTRL_INTFN      5
`define CTRL_W          7
`define CTRL_RST        7'h00

`define IRQ_LINK        0
`define IRQ_COL         2
`define IRQ_W           4
`define IRQ_MASK_RST    4'h0

`endif

/* File: hdl/phy_pins_pkg.sv */
// types shared by the status and control pin block
package phy_pins_pkg;
    typedef enum logic [1:0] {
        LED_MODE1,
        LED_MODE2,
        LED_MODE3
    } led_mode_t;

    typedef struct packed {
        logic link_good;
        logic speed100;
        logic tx_active;
        logic rx_active;
        logic collision;
        logic full_duplex;
    } port_status_t;

    typedef struct packed {
        logic link;
        logic speed;
        logic actcol;
    } led_t;
endpackage

/* File: verification/phy_pins_far_side.sv */
// far side model: LED strap resistors and power down pin pull-up
`timescale 1ns/10ps
module phy_pins_far_side
    import phy_pins_pkg::*;
(
    input  wire led_t pull     [2],
    input  wire led_t led_out  [2],
    input  wire led_t led_oe   [2],
    output led_t      led_in   [2],
    input  wire logic pin_out  [2],
    input  wire logic pin_oe   [2],
    input  wire logic host_low [2],
    output logic      pin_in   [2]
);
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // an undriven LED pin rests at its strap resistor level
            led_in[p] = (led_out[p] & led_oe[p]) | (pull[p] & ~led_oe[p]);
            // wired-and: the pull-up loses to any party pulling low
            pin_in[p] = !(pin_oe[p] && !pin_out[p]) && !host_low[p];
        end
    end
endmodule // phy_pins_far_side

/* File: verification/phy_pins_properties.sv */
// port assertions for the status and control pin block
`timescale 1ns/10ps
module phy_pins_properties
    import phy_pins_pkg::*;
#(
    parameter int NPORT = 2
) (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [11:0]  paddr,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire port_status_t port_status [NPORT],
    input wire logic         mac_clk_dis_strap,
    input wire logic         mac_clock_out,
    input wire led_t         led_out [NPORT],
    input wire led_t         led_oe [NPORT],
    input wire logic         powerdown_irq_pin_in [NPORT],
    input wire logic         powerdown_irq_pin_out [NPORT],
    input wire logic         powerdown_irq_pin_oe [NPORT],
    input wire logic         powerdown [NPORT],
    input wire logic         irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    no_wait_a: assert property (psel && penable |-> pready)
        else $error("wait state inserted");
    bad_addr_a: assert property (psel && penable |->
        pslverr == (paddr > 12'h00C || paddr[1:0] != 2'h0))
        else $error("slave error does not match address");
    // reset must silence the pins even though the checker is reset-gated
    quiet_rst_a: assert property (disable iff (1'b0) !presetn |->
        led_oe[0] == 3'h0 && !mac_clock_out && !irq)
        else $error("outputs active in reset");
    clk_off_a: assert property (mac_clk_dis_strap |-> !mac_clock_out)
        else $error("mac clock runs while disabled");
    pin_drain_a: assert property (powerdown_irq_pin_oe[0] |->
        !powerdown_irq_pin_out[0] && irq)
        else $error("pin pulled without pending irq");
    pd_input_a: assert property (powerdown[0] |->
        !powerdown_irq_pin_in[0] && !powerdown_irq_pin_oe[0])
        else $error("power down without low pin");
    speed_a_a: assert property ($changed(port_status[0].speed100) &&
        led_oe[0].speed && $past(led_oe[0].speed) |->
        $changed(led_out[0].speed))
        else $error("speed led ignores port 0");
    speed_b_a: assert property ($changed(port_status[1].speed100) &&
        led_oe[1].speed && $past(led_oe[1].speed) |->
        $changed(led_out[1].speed))
        else $error("speed led ignores port 1");
    oe_late_a: assert property ($rose(led_oe[0].link) |->
        $past(presetn))
        else $error("led driven before strap sample");
endmodule // phy_pins_properties

bind phy_status_control_pins phy_pins_properties #(.NPORT(NPORT)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .port_status(port_status), .mac_clk_dis_strap(mac_clk_dis_strap),
    .mac_clock_out(mac_clock_out), .led_out(led_out), .led_oe(led_oe),
    .powerdown_irq_pin_in(powerdown_irq_pin_in),
    .powerdown_irq_pin_out(powerdown_irq_pin_out),
    .powerdown_irq_pin_oe(powerdown_irq_pin_oe),
    .powerdown(powerdown), .irq(irq));

/* File: verification/phy_status_control_pins_tb.sv */
// self-checking bench for the status and control pin block
`timescale 1ns/10ps
module phy_status_control_pins_tb;
    import phy_pins_pkg::*;
    // reset starts high so the first assertion gives the flops a negedge
    logic         pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
    logic  [11:0] paddr = 12'h000;
    logic  [31:0] pwdata = 32'h0, prdata, rd;
    logic         pready, pslverr, err, dis = 0, mode = 0, mclk, irq;
    port_status_t ps [2];
    led_t         pull [2], led_in [2], led_out [2], led_oe [2];
    logic         pin_in [2], pin_out [2], pin_oe [2], host_low [2], pd [2];
    int           failures = 0, cmp_count = 0, n;

    always #2 pclk = ~pclk;

    phy_status_control_pins #(.BLINK_HALF_CYC(4)) i_phy_status_control_pins (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_status(ps),
        .mac_clk_dis_strap(dis), .led_mode_strap(mode),
        .mac_clock_out(mclk), .led_in(led_in), .led_out(led_out),
        .led_oe(led_oe), .powerdown_irq_pin_in(pin_in),
        .powerdown_irq_pin_out(pin_out), .powerdown_irq_pin_oe(pin_oe),
        .powerdown(pd), .irq(irq));
    phy_pins_far_side i_phy_pins_far_side (
        .pull(pull), .led_out(led_out), .led_oe(led_oe), .led_in(led_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .host_low(host_low),
        .pin_in(pin_in));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic setps(input logic [5:0] a, input logic [5:0] b);
        @(posedge pclk);
        ps[0] <= a;
        ps[1] <= b;
        cyc(1);
    endtask
    // counts level changes of the mac clock or link led over 100 pclk cycles
    task automatic changes(input logic led);
        logic q, s;
        n = 0;
        q = led ? led_out[0].link : mclk;
        repeat (100) begin
            cyc(1);
            s = led ? led_out[0].link : mclk;
            if (s !== q) n++;
            q = s;
        end
    endtask
    task automatic rst(input logic d, input logic m);
        @(posedge pclk);
        presetn <= 0;
        dis <= d;
        mode <= m;
        repeat (250) @(posedge pclk);
        presetn <= 1;
        cyc(3);
    endtask

    task automatic t_regs;
        apb(0, 12'h004, 0);
        chk(rd, 32'h1);
        chk(led_oe[0], 3'h7);
        apb(1, 12'h000, 32'h7F);
        apb(0, 12'h000, 0);
        chk(rd, 32'h7F);
        apb(1, 12'h000, 0);
        apb(0, 12'h00C, 0);
        chk(rd, 32'h0);
        apb(0, 12'h010, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        $display("done: registers");
    endtask
    task automatic t_mode1;
        setps(6'b100000, 6'b010100);
        chk(led_out[0], 3'h3);
        chk(led_out[1], 3'h3);
        setps(6'b010010, 6'b101000);
        chk(led_out[0], 3'h5);
        chk(led_out[1], 3'h5);
        $display("done: mode one");
    endtask
    task automatic t_mode3;
        apb(1, 12'h000, 32'h0A);
        setps(6'b100001, 6'b000010);
        chk(led_out[0], 3'h2);
        chk(led_out[1], 3'h0);
        apb(1, 12'h000, 32'h02);
        cyc(1);
        chk(led_out[0], 3'h3);
        setps(6'b101000, 6'b0);
        changes(1);
        chk(n, 25);
        $display("done: mode three");
    endtask
    task automatic t_mode2;
        setps(6'b100010, 6'b0);
        chk(led_out[0], 3'h2);
        setps(6'b100001, 6'b0);
        chk(led_out[0], 3'h3);
        setps(6'b101000, 6'b0);
        changes(1);
        chk(n, 25);
        $display("done: mode two");
    endtask
    task automatic t_pd;
        @(posedge pclk);
        host_low[1] <= 1;
        cyc(1);
        chk({pd[1], pd[0]}, 2'h2);
        @(posedge pclk);
        host_low[1] <= 0;
        cyc(1);
        chk(pd[1], 0);
        $display("done: power down");
    endtask
    task automatic t_irq;
        // drop the link first so the next rise is a real change
        setps(6'b0, 6'b0);
        cyc(2);
        apb(0, 12'h008, 0);
        apb(1, 12'h00C, 32'h1);
        apb(1, 12'h000, 32'h20);
        setps(6'b100000, 6'b0);
        cyc(2);
        chk({irq, pin_in[0], pin_in[1], pd[0]}, 4'hA);
        apb(0, 12'h008, 0);
        chk(rd, 32'h1);
        cyc(2);
        chk({irq, pin_in[0]}, 2'h1);
        setps(6'b100000, 6'b100000);
        cyc(2);
        chk(irq, 0);
        apb(0, 12'h008, 0);
        chk(rd, 32'h2);
        $display("done: interrupt");
    endtask
    task automatic t_clk;
        changes(0);
        chk(n, 20);
        apb(1, 12'h000, 32'h1);
        changes(0);
        chk(n, 40);
        rst(1, 1);
        changes(0);
        chk(n, 0);
        apb(0, 12'h004, 0);
        chk(rd, 32'h67);
        $display("done: mac clock");
    endtask

    task automatic summarize;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        summarize();
    end
    initial begin
        ps[0] = '0;
        ps[1] = '0;
        pull[0] = 3'h7;
        pull[1] = 3'h0;
        host_low[0] = 0;
        host_low[1] = 0;
        rst(0, 0);
        t_regs();
        t_mode1();
        t_mode3();
        t_pd();
        t_irq();
        t_clk();
        t_mode2();
        summarize();
    end
endmodule // phy_status_control_pins_tb
